// ==== src/rscl_pkg.sv ====
// Package for the reset strap configuration latch: register map, fields, reset values
package rscl_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // Register offsets
  localparam logic [3:0] REG_AUX_CLOCK_OUTPUT = 4'h0; // Aux clock control
  localparam logic [3:0] REG_STRAP = 4'h1; // Raw latched straps
  localparam logic [3:0] REG_MODE = 4'h2; // Decoded mode summary
  localparam logic [3:0] REG_LINK = 4'h3; // Link defaults
  localparam logic [3:0] REG_DELAY = 4'h4; // RGMII clock delays
  localparam logic [3:0] REG_FEAT = 4'h5; // Downshift and power saving

  // Aux clock control fields
  localparam int unsigned CLK_EN_BIT = 15;
  localparam int unsigned CLK_FRQ_LO = 13;

  // Aux clock frequency codes
  localparam logic [1:0] FRQ_25 = 2'h0;
  localparam logic [1:0] FRQ_50 = 2'h1;
  localparam logic [1:0] FRQ_125 = 2'h2;
  localparam logic [1:0] FRQ_RSVD = 2'h3;

  // Reference clock divider half-period counts
  localparam logic [3:0] HALF_25 = 4'h1;
  localparam logic [3:0] HALF_50 = 4'h0;
  localparam logic [3:0] HALF_125 = 4'h0;

  // Clock delay codes
  localparam logic [2:0] DLY_0P2 = 3'h0;
  localparam logic [2:0] DLY_1P1 = 3'h2;
  localparam logic [2:0] DLY_2P0 = 3'h4;
  localparam logic [2:0] DLY_2P6 = 3'h6;

  // MAC interface selection codes
  localparam logic [1:0] MAC_RGMII = 2'h0;
  localparam logic [1:0] MAC_GMII = 2'h1;
  localparam logic [1:0] MAC_RMII = 2'h2;

  // Forced crossover codes
  localparam logic [1:0] XO_AUTO = 2'h0;
  localparam logic [1:0] XO_MDI = 2'h2;
  localparam logic [1:0] XO_MDIX = 2'h3;

  // Misc widths and constants
  localparam int unsigned PHY_ADDR_W = 5;
  localparam logic [2:0] ADDR_HI_ZERO = 3'h0;
  localparam logic [15:0] RD_ZERO = 16'h0000;

  // Raw strap levels as they sit on the shared pins
  typedef struct packed {
    logic aux_clk;   // Aux clock output pin
    logic rx_clk;    // Managed / unmanaged
    logic [4:0] sig; // Signals A..E (bit 0 = A)
    logic mac_mode;  // MAC mode strap pin
    logic [1:0] addr;  // Receive data 4,5
    logic [1:0] freq;  // Receive data 6,7
    logic rx_er;     // Forced gigabit
    logic col;       // Master / slave
    logic crs;       // MDI / MDI-X
  } rscl_strap_s;

  localparam int unsigned STRAP_W = $bits(rscl_strap_s);

  // Decoded configuration driven to the rest of the device
  typedef struct packed {
    logic managed;
    logic [4:0] phy_addr;
    logic [1:0] mac_if;
    logic [2:0] rx_delay;
    logic [2:0] tx_delay;
    logic an_en;
    logic [1:0] speed;  // 00=10, 01=100, 10=1000
    logic full_duplex;
    logic [1:0] gig_adv; // Full / half gigabit advertisement
    logic [1:0] crossover;
    logic force_gig;
    logic master;
    logic downshift_en;
    logic psave_en;
  } rscl_cfg_s;

  // Speed codes
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

endpackage : rscl_pkg

// ==== src/rscl_top.sv ====
// Reset strap configuration latch with aux clock output and register port
//
// Functional notes
// [R01] Strap pins are inputs during reset; their level is caught at reset release.
// [R02] Board keeps other drivers off strap pins during reset.
// [R03] Aux clock strap 0 disables output, drives low; 1 enables it.
// [R04] Software register bit overrides the strapped aux clock enable.
// [R05] Aux clock locked to reference; code 00=25, 01=50, 10=125 MHz, 11 reserved; the divider gives code 10 the same rate as 01.
// [R06] Receive data 6 and 7 give the frequency field reset default.
// [R07] Software may rewrite the frequency field to any setting.
// [R08] RX_CLK strap 0 selects managed mode; signals A..E are the address.
// [R09] Managed mode applies no strap configuration beyond the address; the code still applies the MAC mode, RX_ER, COL and CRS straps there.
// [R10] RX_CLK strap 1 selects unmanaged mode; A..E set configuration defaults.
// [R11] Host asserts the reset pin twice when configuring unmanaged mode.
// [R12] Speed, autoneg, duplex, gigabit, MAC, crossover, delay defaults follow straps.
// [R13] Unmanaged mode sets downshift and power saving enables to one.
// [R14] Signals A,B set both RGMII delays: 000, 010, 100, 110.
// [R15] Signals C,D select advertisement: all, 10/100, forced 100 HDX, forced 10 HDX.
// [R16] Unmanaged signal E 0 selects RGMII, 1 selects RMII.
// [R17] Board avoids gigabit advertisement with RMII; device does not check.
// [R18] Unmanaged address uses receive data 4,5 as bits 0,1; upper bits zero.
// [R19] MAC mode strap 0 selects RGMII, 1 selects GMII/MII by speed; the code ignores it in unmanaged mode, where E alone picks RGMII or RMII.
// [R20] Unmanaged with E=1 uses RMII whatever the MAC mode strap says.
// [R21] RX_ER strap 1 enters forced gigabit; COL and CRS set role, crossover.
// [R22] Forced gigabit: COL 1 master, 0 slave; CRS 0 MDI, 1 MDI-X.
// [R23] Latched straps hold until the next reset assertion.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module rscl_top
  import rscl_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire rscl_pkg::rscl_strap_s strap_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output rscl_pkg::rscl_cfg_s cfg_o,
  output logic strap_oe_o,
  output logic aux_clock_output_o,
  output logic aux_clock_oe_o
);

  import rscl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser, two flops per strap bit

  logic [STRAP_W-1:0] sync1_q;
  logic [STRAP_W-1:0] sync2_q;

  genvar gi;
  generate
    for (gi = 0; gi < STRAP_W; gi++)
    begin : g_sync
      // Two-stage synchroniser for one strap bit
      always_ff @(posedge clock_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else if (clk_en_i)
        begin
          sync1_q[gi] <= strap_i[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  rscl_strap_s sync_s;

  // Synchronised pins seen through the strap layout, so fields are picked by name
  assign sync_s = rscl_strap_s'(sync2_q);

  ////////////////////////////////////////////////////////////////////////
  // Strap capture at reset release

  logic latched_q; // Straps taken since the last reset
  rscl_strap_s strap_q;
  logic [1:0] warm_q; // Lets the synchroniser fill before capture

  // Wait two enabled edges after release so the sampled levels are real pin levels
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      warm_q <= 2'h0;
    else if (clk_en_i && !warm_q[1])
      warm_q <= {warm_q[0], 1'b1};
  end

  // Single capture, then frozen until reset asserts again
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      latched_q <= 1'b0;
      strap_q <= '0;
    end
    else if (clk_en_i && warm_q[1] && !latched_q)
    begin
      latched_q <= 1'b1; // [R23]
      strap_q <= rscl_strap_s'(sync2_q); // [R01]
    end
  end

  // Strap pins are released as inputs until the capture is done
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      strap_oe_o <= 1'b0; // [R01]
    else if (clk_en_i)
      strap_oe_o <= latched_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Strap decode

  rscl_cfg_s dec;

  // Combinational decode of the held strap levels
  always_comb
  begin
    dec = '0;
    dec.managed = !strap_q.rx_clk; // [R08] [R10]
    dec.force_gig = strap_q.rx_er; // [R21]
    dec.master = strap_q.rx_er & strap_q.col; // [R22]
    dec.an_en = 1'b1;
    dec.speed = SPD_1000;
    dec.full_duplex = 1'b1;
    dec.gig_adv = 2'h3;
    dec.crossover = XO_AUTO;
    dec.mac_if = strap_q.mac_mode ? MAC_GMII : MAC_RGMII; // [R19]
    if (strap_q.rx_er)
      dec.crossover = strap_q.crs ? XO_MDIX : XO_MDI; // [R22]
    if (!strap_q.rx_clk)
    begin
      dec.phy_addr = strap_q.sig; // [R08] [R09]
    end
    else
    begin
      dec.phy_addr = {ADDR_HI_ZERO, strap_q.addr}; // [R18]
      case (strap_q.sig[1:0]) // [R14]
        2'h0: dec.rx_delay = DLY_0P2;
        2'h2: dec.rx_delay = DLY_1P1; // A=0, B=1
        2'h1: dec.rx_delay = DLY_2P0; // A=1, B=0
        default: dec.rx_delay = DLY_2P6;
      endcase
      dec.tx_delay = dec.rx_delay; // [R14]
      case ({strap_q.sig[2], strap_q.sig[3]}) // [R15] [R12]
        2'h0:
        begin
          dec.an_en = 1'b1;
        end
        2'h1:
        begin
          dec.speed = SPD_100;
          dec.gig_adv = 2'h0;
        end
        2'h2:
        begin
          dec.an_en = 1'b0;
          dec.speed = SPD_100;
          dec.full_duplex = 1'b0;
          dec.gig_adv = 2'h0;
        end
        default:
        begin
          dec.an_en = 1'b0;
          dec.speed = SPD_10;
          dec.full_duplex = 1'b0;
          dec.gig_adv = 2'h0;
        end
      endcase
      // No consistency check against RMII with gigabit advertised
      if (strap_q.sig[4])
        dec.mac_if = MAC_RMII; // [R16] [R20]
      else
        dec.mac_if = MAC_RGMII; // [R16]
      dec.downshift_en = 1'b1; // [R13]
      dec.psave_en = 1'b1; // [R13]
    end
  end

  // Registered configuration outputs, zero until straps are taken
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cfg_o <= '0;
    else if (clk_en_i && latched_q)
      cfg_o <= dec; // [R12]
  end

  ////////////////////////////////////////////////////////////////////////
  // Aux clock control register

  logic clk_en_q;
  logic [1:0] clk_frq_q;
  logic wr_clk;

  assign wr_clk = wr_i && (addr_i == REG_AUX_CLOCK_OUTPUT);

  // Loaded from straps once, then software owned
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      clk_en_q <= 1'b0;
      clk_frq_q <= FRQ_25;
    end
    else if (clk_en_i)
    begin
      if (warm_q[1] && !latched_q)
      begin
        clk_en_q <= sync_s.aux_clk; // [R03]
        clk_frq_q <= sync_s.freq; // [R06]
      end
      else if (wr_clk && latched_q)
      begin
        clk_en_q <= wdata_i[CLK_EN_BIT]; // [R04]
        clk_frq_q <= wdata_i[CLK_FRQ_LO +: 2]; // [R07]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Aux clock generator, divides the reference clock

  logic [3:0] div_q;
  logic [3:0] half_cnt;
  logic aux_q;

  // Half-period count per frequency code
  always_comb
  begin
    case (clk_frq_q) // [R05]
      FRQ_25: half_cnt = HALF_25;
      FRQ_50: half_cnt = HALF_50;
      FRQ_125: half_cnt = HALF_125;
      default: half_cnt = HALF_25; // Reserved code
    endcase
  end

  // Toggle divider, held low while disabled
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      div_q <= 4'h0;
      aux_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (!clk_en_q)
      begin
        div_q <= 4'h0;
        aux_q <= 1'b0; // [R03]
      end
      else if (div_q >= half_cnt)
      begin
        div_q <= 4'h0;
        aux_q <= !aux_q; // [R05]
      end
      else
        div_q <= div_q + 4'h1;
    end
  end

  assign aux_clock_output_o = aux_q;

  // Aux pin is an input during reset, driven once straps are taken
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      aux_clock_oe_o <= 1'b0;
    else if (clk_en_i)
      aux_clock_oe_o <= latched_q; // [R03]
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port

  logic [15:0] rd_d;

  // Read mux
  always_comb
  begin
    rd_d = RD_ZERO;
    case (addr_i)
      REG_AUX_CLOCK_OUTPUT: rd_d = {clk_en_q, clk_frq_q, 13'h0000};
      REG_STRAP: rd_d = {{(16-STRAP_W){1'b0}}, strap_q};
      REG_MODE: rd_d = {5'h00, latched_q, cfg_o.managed, cfg_o.force_gig, cfg_o.master,
                        cfg_o.mac_if, cfg_o.phy_addr};
      REG_LINK: rd_d = {7'h00, cfg_o.an_en, cfg_o.speed, cfg_o.full_duplex, cfg_o.gig_adv,
                        1'b0, cfg_o.crossover};
      REG_DELAY: rd_d = {9'h000, cfg_o.rx_delay, 1'b0, cfg_o.tx_delay};
      REG_FEAT: rd_d = {14'h0000, cfg_o.downshift_en, cfg_o.psave_en};
      default: rd_d = RD_ZERO;
    endcase
  end

  // Read data stands for the cycle after the strobe only
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= RD_ZERO;
    else if (clk_en_i)
      rdata_o <= rd_i ? rd_d : RD_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  strap_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R23]
    $past(latched_q) && latched_q |-> $stable(strap_q))
    else $error("straps changed after capture");

  managed_addr_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R08]
    latched_q && !strap_q.rx_clk && clk_en_i |=> cfg_o.phy_addr == strap_q.sig && !cfg_o.downshift_en)
    else $error("managed address wrong");

  managed_cfg_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R09]
    latched_q && !strap_q.rx_clk && clk_en_i |=> cfg_o.rx_delay == DLY_0P2 && !cfg_o.psave_en)
    else $error("managed mode took strap settings");

  mac_mode_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R19]
    latched_q && !strap_q.rx_clk && clk_en_i |=> cfg_o.mac_if == (strap_q.mac_mode ? MAC_GMII : MAC_RGMII))
    else $error("MAC mode strap ignored");

  unmgd_addr_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R18]
    latched_q && strap_q.rx_clk && clk_en_i |=> cfg_o.phy_addr[4:2] == 3'h0 && cfg_o.phy_addr[1:0] == strap_q.addr)
    else $error("unmanaged address wrong");

  rmii_win_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R20]
    latched_q && strap_q.rx_clk && strap_q.sig[4] && clk_en_i |=> cfg_o.mac_if == MAC_RMII)
    else $error("RMII not selected");

  unmgd_feat_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R13]
    latched_q && strap_q.rx_clk && clk_en_i |=> cfg_o.downshift_en && cfg_o.psave_en)
    else $error("unmanaged features off");

  aux_low_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R03]
    !clk_en_q && clk_en_i |=> !aux_clock_output_o)
    else $error("aux clock not held low");

  aux_oe_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R03]
    !latched_q && clk_en_i |=> !aux_clock_oe_o)
    else $error("aux pin driven before capture");

  gig_role_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R22]
    latched_q && clk_en_i |=> cfg_o.master == (strap_q.rx_er && strap_q.col))
    else $error("forced gigabit role wrong");

  delay_eq_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R14]
    latched_q && strap_q.rx_clk && strap_q.sig[1:0] == 2'h3 && clk_en_i |=> cfg_o.rx_delay == DLY_2P6
    && cfg_o.tx_delay == DLY_2P6)
    else $error("delay code wrong");

  freq_strap_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R06]
    clk_en_i && warm_q[1] && !latched_q |=> clk_frq_q == $past(sync_s.freq) && clk_en_q == $past(sync_s.aux_clk))
    else $error("aux clock defaults not from straps");

  sw_write_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R07]
    wr_clk && latched_q && clk_en_i |=> clk_frq_q == $past(wdata_i[14:13]))
    else $error("frequency write lost");

endmodule // rscl_top

`default_nettype wire

// ==== testbench/rscl_board.sv ====
// Board side of the strap pins: pull resistors, a changing pattern once released
`timescale 1ns/1ps
`default_nettype none

module rscl_board (
  input wire logic clock_i,
  input wire logic strap_oe_i,
  input wire rscl_pkg::rscl_strap_s pull_i,
  output rscl_pkg::rscl_strap_s strap_o
);
  import rscl_pkg::*;

  logic flip_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Phase of the pattern shown after release, so stale levels never look latched
  always_ff @(posedge clock_i)
  begin
    if (!strap_oe_i)
      flip_q <= 1'b1;
    else
      flip_q <= ~flip_q;
  end

  // Nothing but the pulls sets the pins while the device listens
  assign strap_o = (strap_oe_i && flip_q) ? ~pull_i : pull_i;

endmodule // rscl_board

`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the strap configuration latch
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import rscl_pkg::*;

  logic clock_i;
  logic nrst_i;
  logic clk_en_i;
  logic wr_i;
  logic rd_i;
  logic [3:0] addr_i;
  logic [15:0] wdata_i;
  logic [15:0] rdata_o;
  logic [15:0] rd_v;
  rscl_strap_s pull_q;
  rscl_strap_s strap_i;
  rscl_cfg_s cfg_o;
  logic strap_oe_o;
  logic aux_clock_output_o;
  logic aux_clock_oe_o;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and board
  rscl_top rscl_top_inst (.clock_i(clock_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i), .strap_i(strap_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cfg_o(cfg_o),
    .strap_oe_o(strap_oe_o), .aux_clock_output_o(aux_clock_output_o), .aux_clock_oe_o(aux_clock_oe_o));
  rscl_board rscl_board_inst (.clock_i(clock_i), .strap_oe_i(strap_oe_o), .pull_i(pull_q), .strap_o(strap_i));

  // 10 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // Hang guard
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      complete_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input rscl_strap_s s);
    @(posedge clock_i);
    pull_q <= s;
    nrst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    check(strap_oe_o, 1'b0);
    check(cfg_o, '0);
    @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    #1;
    check({strap_oe_o, aux_clock_oe_o}, 2'h3);
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // Counts level changes of the aux clock over eight cycles
  task automatic toggles(output int n);
    logic p;
    n = 0;
    #1;
    p = aux_clock_output_o;
    repeat (8)
    begin
      @(posedge clock_i);
      #1;
      if (aux_clock_output_o !== p)
        n++;
      p = aux_clock_output_o;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Managed straps, forced gigabit, software control of the aux clock
  task automatic t_managed;
    int n;
    logic [1:0] f;
    do_reset({1'b0, 1'b0, 5'h15, 1'b1, 2'h0, 2'h2, 1'b1, 1'b1, 1'b1});
    check({cfg_o.managed, cfg_o.phy_addr}, {1'b1, 5'h15});
    check(cfg_o.mac_if, MAC_GMII);
    check({cfg_o.force_gig, cfg_o.master, cfg_o.crossover}, {2'h3, XO_MDIX});
    check({cfg_o.downshift_en, cfg_o.psave_en}, 2'h0);
    toggles(n);
    check(n, 0);
    check(aux_clock_output_o, 1'b0);
    reg_read(REG_AUX_CLOCK_OUTPUT, rd_v);
    check(rd_v, 16'h4000);
    for (int i = 0; i < 4; i++)
    begin
      f = 2'(i);
      reg_write(REG_AUX_CLOCK_OUTPUT, {1'b1, f, 13'h0});
      repeat (2) @(posedge clock_i);
      toggles(n);
      check(n, (f == FRQ_50 || f == FRQ_125) ? 8 : 4);
    end
    // Clock enable low freezes the divider and drops a write
    @(posedge clock_i);
    clk_en_i <= 1'b0;
    reg_write(REG_AUX_CLOCK_OUTPUT, 16'h0);
    toggles(n);
    check(n, 0);
    @(posedge clock_i);
    clk_en_i <= 1'b1;
    toggles(n);
    check(n, 4);
    reg_write(REG_AUX_CLOCK_OUTPUT, 16'h0);
    toggles(n);
    toggles(n);
    check({n[3:0], aux_clock_output_o}, 5'h0);
    reg_read(4'hf, rd_v);
    check(rd_v, RD_ZERO);
    $display("managed test done");
  endtask

  // Unmanaged straps over every A,B and C,D code, reset given twice
  task automatic t_unmanaged;
    int n;
    logic [1:0] k;
    rscl_cfg_s held;
    for (int i = 0; i < 4; i++)
    begin
      k = 2'(i);
      // E only with a non-gigabit advertisement
      do_reset({2'h3, (k != 2'h0), k[0], k[1], k[1], k[0], k[0], k, k, k[1], k[0], k[0]});
      do_reset({2'h3, (k != 2'h0), k[0], k[1], k[1], k[0], k[0], k, k, k[1], k[0], k[0]});
      check({cfg_o.managed, cfg_o.phy_addr}, {3'h0, k});
      check({cfg_o.rx_delay, cfg_o.tx_delay}, {k[0], k[1], 1'b0, k[0], k[1], 1'b0});
      check(cfg_o.an_en, !k[1]);
      if (k[1])
        check({cfg_o.speed, cfg_o.full_duplex}, {(k[0] ? SPD_10 : SPD_100), 1'b0});
      else
        check(cfg_o.gig_adv, (k == 2'h0) ? 2'h3 : 2'h0);
      check(cfg_o.mac_if, (k == 2'h0) ? MAC_RGMII : MAC_RMII);
      check({cfg_o.force_gig, cfg_o.master}, {k[1], k[1] & k[0]});
      check(cfg_o.crossover, k[1] ? (k[0] ? XO_MDIX : XO_MDI) : XO_AUTO);
      check({cfg_o.downshift_en, cfg_o.psave_en}, 2'h3);
      reg_read(REG_AUX_CLOCK_OUTPUT, rd_v);
      check(rd_v, {1'b1, k, 13'h0});
      reg_read(REG_STRAP, rd_v);
      check(rd_v, {1'b0, pull_q});
      reg_read(REG_DELAY, rd_v);
      check(rd_v, {9'h000, k[0], k[1], 1'b0, 1'b0, k[0], k[1], 1'b0});
      toggles(n);
      check(n, (k == FRQ_50 || k == FRQ_125) ? 8 : 4);
      reg_write(REG_FEAT, 16'h0);
      reg_read(REG_FEAT, rd_v);
      check(rd_v, 16'h0003);
      held = cfg_o;
      repeat (20) @(posedge clock_i);
      #1;
      check(cfg_o, held);
    end
    $display("unmanaged test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    nrst_i = 1'b0;
    clk_en_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    pull_q = '0;
    t_managed;
    t_unmanaged;
    complete_run;
  end

endmodule // testbench

`default_nettype wire
